// ===== src/lcdc_device.sv
// LCD controller command decoder: device end of the command/data bus
`timescale 1ns/1ps
`include "lcdc_params.svh"

module lcdc_device
    import lcdc_pkg::*;
#(
    parameter int RESET_CYC = `LCDC_RESET_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    lcdc_if.device bus,
    output logic invert_pixels,
    output logic all_points_on,
    output logic display_on,
    output logic power_save,
    output logic bias_1_7,
    output logic scan_reverse,
    output logic booster_en,
    output logic regulator_en,
    output logic follower_en,
    output logic [2:0] resistor_ratio,
    output logic [5:0] volume_drive_level,
    output logic [7:0] column_addr,
    output logic rmw_active,
    output logic test_mode,
    output logic data_write_pulse
);
    // ==========================================================
    // State
    // ==========================================================
    lcdc_state_t state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic inv_ff, nxt_inv, allon_ff, nxt_allon, don_ff, nxt_don;
    logic bias_ff, nxt_bias, scan_ff, nxt_scan;
    logic [2:0] pwr_ff, nxt_pwr, ratio_ff, nxt_ratio;
    logic [5:0] vol_ff, nxt_vol;
    logic [7:0] col_ff, nxt_col, save_ff, nxt_save;
    logic rmw_ff, nxt_rmw, test_ff, nxt_test, rst_ip_ff, nxt_rst_ip;
    logic dwr_ff, nxt_dwr;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic hard_rst;

    function automatic logic match(input logic [7:0] b, input logic [7:0] code,
                                   input logic [7:0] mask);
        match = ((b & mask) == code);
    endfunction : match

    function automatic logic [7:0] col_inc(input logic [7:0] c);
        col_inc = (c == `LCDC_COL_MAX) ? c : c + 8'h01;
    endfunction : col_inc

    assign hard_rst = rst || !bus.reset_n;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_inv = inv_ff;
        nxt_allon = allon_ff;
        nxt_don = don_ff;
        nxt_bias = bias_ff;
        nxt_scan = scan_ff;
        nxt_pwr = pwr_ff;
        nxt_ratio = ratio_ff;
        nxt_vol = vol_ff;
        nxt_col = col_ff;
        nxt_save = save_ff;
        nxt_rmw = rmw_ff;
        nxt_test = test_ff;
        nxt_rst_ip = rst_ip_ff;
        nxt_dwr = 1'b0;
        nxt_rvalid = 1'b0;
        nxt_rdata = rdata_ff;
        // Busy counter runs down after a software reset
        if (state_ff == LCDC_ST_BUSY) begin
            if (cnt_ff == 8'h00) begin
                nxt_state = LCDC_ST_IDLE;
                nxt_rst_ip = 1'b0;
            end else begin
                nxt_cnt = cnt_ff - 8'h01;
            end
        end
        if (bus.rd_stb) begin
            nxt_rvalid = 1'b1;
            if (!bus.command_data_select) begin
                nxt_rdata = 8'h00;
                nxt_rdata[`LCDC_BIT_BUSY] = (state_ff == LCDC_ST_BUSY);
                nxt_rdata[`LCDC_BIT_DISPOFF] = !don_ff;
                nxt_rdata[`LCDC_BIT_RST] = rst_ip_ff;
            end else begin
                // No display memory here; reads return the column
                nxt_rdata = col_ff;
                if (!rmw_ff) begin
                    nxt_col = col_inc(col_ff);
                end
            end
        end else if (bus.wr_stb && bus.command_data_select) begin
            nxt_dwr = 1'b1;
            nxt_col = col_inc(col_ff);
        end else if (bus.wr_stb) begin
            if (state_ff == LCDC_ST_BUSY) begin
                nxt_state = LCDC_ST_BUSY;
            end else if (state_ff == LCDC_ST_VOL) begin
                nxt_vol = bus.wdata[5:0];
                nxt_state = LCDC_ST_IDLE;
            // reset still acts in test mode, below
            end else if (test_ff && bus.wdata != `LCDC_CMD_RESET) begin
                // Test mode leaves on NOP here; software reset clears it too
                if (bus.wdata == `LCDC_CMD_NOP) begin
                    nxt_test = 1'b0;
                end
            end else if (match(bus.wdata, `LCDC_CMD_POLARITY, `LCDC_MASK_1BIT)) begin
                nxt_inv = bus.wdata[`LCDC_BIT_D0];
            end else if (match(bus.wdata, `LCDC_CMD_ALLON, `LCDC_MASK_1BIT)) begin
                nxt_allon = bus.wdata[`LCDC_BIT_D0];
            end else if (match(bus.wdata, `LCDC_CMD_BIAS, `LCDC_MASK_1BIT)) begin
                nxt_bias = bus.wdata[`LCDC_BIT_D0];
            end else if (match(bus.wdata, `LCDC_CMD_DISP_ONOFF, `LCDC_MASK_1BIT)) begin
                nxt_don = bus.wdata[`LCDC_BIT_D0];
            end else if (bus.wdata == `LCDC_CMD_RMW) begin
                if (!rmw_ff) begin
                    nxt_save = col_ff;
                end
                nxt_rmw = 1'b1;
            end else if (bus.wdata == `LCDC_CMD_END) begin
                if (rmw_ff) begin
                    nxt_col = save_ff;
                end
                nxt_rmw = 1'b0;
            end else if (bus.wdata == `LCDC_CMD_RESET) begin
                nxt_col = 8'h00;
                nxt_scan = 1'b0;
                nxt_ratio = `LCDC_RATIO_RST;
                nxt_vol = `LCDC_VOL_RST;
                nxt_rmw = 1'b0;
                nxt_test = 1'b0;
                nxt_state = LCDC_ST_BUSY;
                nxt_cnt = 8'(RESET_CYC);
                nxt_rst_ip = 1'b1;
            end else if (bus.wdata == `LCDC_CMD_VOLMODE) begin
                nxt_state = LCDC_ST_VOL;
            end else if (match(bus.wdata, `LCDC_CMD_TEST, `LCDC_MASK_TEST)) begin
                nxt_test = 1'b1;
            // scan from D3, low bits ignored
            end else if (match(bus.wdata, `LCDC_CMD_SCAN, `LCDC_MASK_SCAN)) begin
                nxt_scan = bus.wdata[`LCDC_BIT_D3];
            end else if (match(bus.wdata, `LCDC_CMD_POWER, `LCDC_MASK_3BIT)) begin
                nxt_pwr = bus.wdata[2:0];
            end else if (match(bus.wdata, `LCDC_CMD_RATIO, `LCDC_MASK_3BIT)) begin
                nxt_ratio = bus.wdata[2:0];
            // Column set; acts during RMW too, the host does not filter these
            end else if (match(bus.wdata, `LCDC_CMD_COL_HI, `LCDC_MASK_4BIT)) begin
                nxt_col = {bus.wdata[3:0], col_ff[3:0]};
            end else if (match(bus.wdata, `LCDC_CMD_COL_LO, `LCDC_MASK_4BIT)) begin
                nxt_col = {col_ff[7:4], bus.wdata[3:0]};
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            state_ff <= LCDC_ST_BUSY;
            cnt_ff <= 8'(RESET_CYC);
            inv_ff <= 1'b0;
            allon_ff <= 1'b0;
            don_ff <= 1'b0;
            bias_ff <= 1'b0;
            scan_ff <= 1'b0;
            pwr_ff <= 3'h0;
            ratio_ff <= `LCDC_RATIO_RST;
            vol_ff <= `LCDC_VOL_RST;
            col_ff <= 8'h00;
            save_ff <= 8'h00;
            rmw_ff <= 1'b0;
            test_ff <= 1'b0;
            rst_ip_ff <= 1'b1;
            dwr_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            inv_ff <= nxt_inv;
            allon_ff <= nxt_allon;
            don_ff <= nxt_don;
            bias_ff <= nxt_bias;
            scan_ff <= nxt_scan;
            pwr_ff <= nxt_pwr;
            ratio_ff <= nxt_ratio;
            vol_ff <= nxt_vol;
            col_ff <= nxt_col;
            save_ff <= nxt_save;
            rmw_ff <= nxt_rmw;
            test_ff <= nxt_test;
            rst_ip_ff <= nxt_rst_ip;
            dwr_ff <= nxt_dwr;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ==========================================================
    // Outputs (decoded outputs below are single-gate views of flops)
    // ==========================================================
    // all points lit wins over polarity
    assign invert_pixels = inv_ff && !allon_ff;
    assign all_points_on = allon_ff;
    assign display_on = don_ff;
    // all points while off is power save
    assign power_save = allon_ff && !don_ff;
    assign bias_1_7 = bias_ff;
    assign scan_reverse = scan_ff;
    assign booster_en = pwr_ff[2] && don_ff;
    assign regulator_en = pwr_ff[1] && don_ff;
    assign follower_en = pwr_ff[0] && don_ff;
    assign resistor_ratio = ratio_ff;
    assign volume_drive_level = vol_ff;
    assign column_addr = col_ff;
    assign rmw_active = rmw_ff;
    assign test_mode = test_ff;
    assign data_write_pulse = dwr_ff;
    assign bus.rdata = rdata_ff;
    assign bus.rvalid = rvalid_ff;
endmodule : lcdc_device

// ===== inc/lcdc_params.svh
// Command codes, field positions and timing counts of the LCD command decoder
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH

`define LCDC_CMD_POLARITY 8'ha6
`define LCDC_CMD_ALLON 8'ha4
`define LCDC_CMD_BIAS 8'ha2
`define LCDC_CMD_DISP_ONOFF 8'hae
`define LCDC_CMD_RMW 8'he0
`define LCDC_CMD_END 8'hee
`define LCDC_CMD_RESET 8'he2
`define LCDC_CMD_NOP 8'he3
`define LCDC_CMD_SCAN 8'hc0
`define LCDC_CMD_POWER 8'h28
`define LCDC_CMD_RATIO 8'h20
`define LCDC_CMD_VOLMODE 8'h81
`define LCDC_CMD_COL_HI 8'h10
`define LCDC_CMD_COL_LO 8'h00
`define LCDC_CMD_TEST 8'hfc
`define LCDC_MASK_1BIT 8'hfe
`define LCDC_MASK_3BIT 8'hf8
`define LCDC_MASK_4BIT 8'hf0
`define LCDC_MASK_SCAN 8'hf0
`define LCDC_MASK_TEST 8'hfc
`define LCDC_BIT_D0 0
`define LCDC_BIT_D3 3
`define LCDC_BIT_BUSY 7
`define LCDC_BIT_DISPOFF 5
`define LCDC_BIT_RST 4
`define LCDC_COL_MAX 8'h83
`define LCDC_RATIO_RST 3'h0
`define LCDC_VOL_RST 6'h20
`define LCDC_VOL_DEFAULT 6'h20
`define LCDC_RESET_NS 1000
`define LCDC_CLK_NS 50
`define LCDC_RESET_CYC ((`LCDC_RESET_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)

`endif

// ===== inc/lcdc_pkg.sv
// Types shared by both ends of the LCD command decoder
package lcdc_pkg;
    typedef enum logic [1:0] {
        LCDC_ST_IDLE = 2'b00,
        LCDC_ST_BUSY = 2'b01,
        LCDC_ST_VOL = 2'b10
    } lcdc_state_t;
    typedef enum logic [2:0] {
        LCDC_H_IDLE = 3'b000,
        LCDC_H_RESET = 3'b001,
        LCDC_H_POLL = 3'b010,
        LCDC_H_WRITE = 3'b011,
        LCDC_H_READ = 3'b100,
        LCDC_H_HOLD = 3'b101
    } lcdc_host_state_t;
endpackage : lcdc_pkg

// ===== inc/lcdc_if.sv
// Parallel command/data bus between host and LCD controller
`timescale 1ns/1ps
interface lcdc_if;
    logic reset_n;
    logic command_data_select;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    modport device (
        input reset_n, command_data_select, wr_stb, rd_stb, wdata,
        output rdata, rvalid
    );
    modport host (
        output reset_n, command_data_select, wr_stb, rd_stb, wdata,
        input rdata, rvalid
    );
endinterface : lcdc_if

// ===== src/lcdc_host.sv
// Host end: drives reset, commands, data and status polls onto the bus
`timescale 1ns/1ps
`include "lcdc_params.svh"

module lcdc_host
    import lcdc_pkg::*;
#(
    parameter int RESET_CYC = `LCDC_RESET_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    lcdc_if.host bus,
    input wire logic req_valid,
    input wire logic req_read,
    input wire logic req_is_data,
    input wire logic [7:0] req_byte,
    output logic req_ready,
    output logic [7:0] resp_byte,
    output logic resp_valid
);
    // ==========================================================
    // State
    // ==========================================================
    lcdc_host_state_t st_ff, nxt_st;
    logic [7:0] cnt_ff, nxt_cnt;
    logic rstn_ff, nxt_rstn, cds_ff, nxt_cds, wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [7:0] wd_ff, nxt_wd, pend_ff, nxt_pend, resp_ff, nxt_resp;
    logic pend_rd_ff, nxt_pend_rd, pend_dat_ff, nxt_pend_dat, rv_ff, nxt_rv;
    logic rdy_ff, nxt_rdy;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_rstn = rstn_ff;
        nxt_cds = cds_ff;
        nxt_wr = 1'b0;
        nxt_rd = 1'b0;
        nxt_wd = wd_ff;
        nxt_pend = pend_ff;
        nxt_pend_rd = pend_rd_ff;
        nxt_pend_dat = pend_dat_ff;
        nxt_resp = resp_ff;
        nxt_rv = 1'b0;
        nxt_rdy = 1'b0;
        case (st_ff)
            // hold hardware reset after power up
            LCDC_H_RESET: begin
                if (cnt_ff == 8'h00) begin
                    nxt_rstn = 1'b1;
                    nxt_st = LCDC_H_IDLE;
                    nxt_rdy = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            LCDC_H_IDLE: begin
                nxt_rdy = 1'b1;
                if (req_valid && rdy_ff) begin
                    nxt_rdy = 1'b0;
                    nxt_pend = req_byte;
                    nxt_pend_rd = req_read;
                    nxt_pend_dat = req_is_data;
                    // Poll status first so no command lands while busy
                    nxt_cds = 1'b0;
                    nxt_rd = 1'b1;
                    nxt_st = LCDC_H_POLL;
                end
            end
            LCDC_H_POLL: begin
                if (bus.rvalid) begin
                    if (bus.rdata[`LCDC_BIT_BUSY]) begin
                        nxt_rd = 1'b1;
                    end else if (pend_rd_ff) begin
                        nxt_cds = pend_dat_ff;
                        nxt_rd = 1'b1;
                        nxt_st = LCDC_H_READ;
                    end else begin
                        nxt_cds = pend_dat_ff;
                        nxt_wd = pend_ff;
                        nxt_wr = 1'b1;
                        nxt_st = LCDC_H_WRITE;
                    end
                end
            end
            LCDC_H_READ: begin
                if (bus.rvalid) begin
                    nxt_resp = bus.rdata;
                    nxt_rv = 1'b1;
                    nxt_st = LCDC_H_HOLD;
                end
            end
            LCDC_H_WRITE: begin
                nxt_st = LCDC_H_HOLD;
            end
            LCDC_H_HOLD: begin
                nxt_rdy = 1'b1;
                nxt_st = LCDC_H_IDLE;
            end
            default: begin
                nxt_st = LCDC_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff <= LCDC_H_RESET;
            cnt_ff <= 8'(RESET_CYC);
            rstn_ff <= 1'b0;
            cds_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            wd_ff <= 8'h00;
            pend_ff <= 8'h00;
            pend_rd_ff <= 1'b0;
            pend_dat_ff <= 1'b0;
            resp_ff <= 8'h00;
            rv_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            rstn_ff <= nxt_rstn;
            cds_ff <= nxt_cds;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            wd_ff <= nxt_wd;
            pend_ff <= nxt_pend;
            pend_rd_ff <= nxt_pend_rd;
            pend_dat_ff <= nxt_pend_dat;
            resp_ff <= nxt_resp;
            rv_ff <= nxt_rv;
            rdy_ff <= nxt_rdy;
        end
    end

    // are up to the user feeding requests in order
    assign bus.reset_n = rstn_ff;
    assign bus.command_data_select = cds_ff;
    assign bus.wr_stb = wr_ff;
    assign bus.rd_stb = rd_ff;
    assign bus.wdata = wd_ff;
    assign req_ready = rdy_ff;
    assign resp_byte = resp_ff;
    assign resp_valid = rv_ff;
endmodule : lcdc_host

// ===== tb/lcdc_sva.sv
// Checker: bus timing and decoded settings of the LCD command decoder
`timescale 1ns/1ps
`include "lcdc_params.svh"

module lcdc_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic command_data_select,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wdata,
    input wire logic rvalid,
    input wire logic invert_pixels,
    input wire logic all_points_on,
    input wire logic display_on,
    input wire logic power_save,
    input wire logic bias_1_7,
    input wire logic scan_reverse,
    input wire logic booster_en,
    input wire logic regulator_en,
    input wire logic follower_en,
    input wire logic [2:0] resistor_ratio,
    input wire logic [5:0] volume_drive_level,
    input wire logic [7:0] column_addr,
    input wire logic rmw_active,
    input wire logic test_mode,
    input wire logic data_write_pulse
);
    // ==========================================
    // Helper state
    logic vol_ff;
    logic nxt_vol_ff;
    logic [7:0] mark_col_ff;
    logic [7:0] nxt_mark_col_ff;
    logic cmd_wr;

    // Host polls busy first, so only volume and test mode can swallow a command
    assign cmd_wr = wr_stb && !command_data_select && reset_n && !vol_ff && !test_mode;

    always_comb begin
        nxt_vol_ff = vol_ff;
        nxt_mark_col_ff = mark_col_ff;
        if (rst || !reset_n) begin
            nxt_vol_ff = 1'b0;
        end else if (wr_stb && !command_data_select) begin
            nxt_vol_ff = !vol_ff && !test_mode && (wdata == `LCDC_CMD_VOLMODE);
        end
        if (cmd_wr && wdata == `LCDC_CMD_RMW && !rmw_active) begin
            nxt_mark_col_ff = column_addr;
        end
    end

    always_ff @(posedge ref_clk) begin
        vol_ff <= nxt_vol_ff;
        mark_col_ff <= nxt_mark_col_ff;
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_vol_value;
        vol_ff && wr_stb && !command_data_select && reset_n;
    endsequence
    sequence s_rmw_end;
        cmd_wr && wdata == `LCDC_CMD_END && rmw_active;
    endsequence

    AST_POLARITY: assert property (cmd_wr && (wdata & 8'hfe) == 8'ha6 |=>
        invert_pixels == ($past(wdata[0]) && !all_points_on)) else $error("polarity wrong");
    AST_ALL_ON: assert property (cmd_wr && (wdata & 8'hfe) == 8'ha4 |=>
        all_points_on == $past(wdata[0])) else $error("all points wrong");
    AST_PRIORITY: assert property (all_points_on |-> !invert_pixels)
        else $error("inversion over all points");
    AST_PWR_SAVE: assert property (cmd_wr && (wdata & 8'hfe) == 8'ha4 && !display_on |=>
        power_save == $past(wdata[0])) else $error("power save wrong");
    AST_BIAS: assert property (cmd_wr && (wdata & 8'hfe) == 8'ha2 |=>
        bias_1_7 == $past(wdata[0])) else $error("bias wrong");
    AST_SCAN: assert property (cmd_wr && wdata[7:4] == 4'hc |=>
        scan_reverse == $past(wdata[3])) else $error("scan wrong");
    AST_POWER: assert property (cmd_wr && wdata[7:3] == 5'h05 |=>
        {booster_en, regulator_en, follower_en} == ($past(wdata[2:0]) & {3{display_on}}))
        else $error("power enables wrong");
    AST_RATIO: assert property (cmd_wr && wdata[7:3] == 5'h04 |=>
        resistor_ratio == $past(wdata[2:0])) else $error("ratio wrong");
    AST_VOLUME: assert property (s_vol_value |=>
        volume_drive_level == $past(wdata[5:0]) && $stable(invert_pixels))
        else $error("volume wrong");
    AST_RMW_READ: assert property (rmw_active && rd_stb && command_data_select |=>
        $stable(column_addr)) else $error("column moved on read");
    AST_RMW_END: assert property (s_rmw_end |=> column_addr == mark_col_ff && !rmw_active)
        else $error("column not restored");
    AST_COL_STEP: assert property (wr_stb && command_data_select && reset_n |=>
        column_addr == (($past(column_addr) == 8'h83) ? 8'h83 : $past(column_addr) + 8'h01))
        else $error("column step wrong");
    AST_SW_RESET: assert property (wr_stb && !command_data_select && !vol_ff &&
        wdata == `LCDC_CMD_RESET |=> column_addr == 8'h00 && !scan_reverse && !rmw_active
        && !test_mode
        && resistor_ratio == `LCDC_RATIO_RST && volume_drive_level == `LCDC_VOL_RST)
        else $error("software reset incomplete");
    AST_DATA_ONLY: assert property (wr_stb && command_data_select && reset_n |=>
        $stable({invert_pixels, bias_1_7, scan_reverse, resistor_ratio}) && data_write_pulse)
        else $error("data byte changed settings");
    AST_RD_ANSWER: assert property (rd_stb && reset_n |=> rvalid)
        else $error("read not answered");
endmodule : lcdc_sva

// ===== tb/lcdc_bench.sv
// Testbench: host and device joined, driven from the host user port
`timescale 1ns/1ps
`include "lcdc_params.svh"

module lcdc_bench;
    localparam int RST_CYC = 2;
    localparam int LIMIT = 5000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic req_is_data = 1'b0;
    logic [7:0] req_byte = 8'h00;
    logic req_ready, resp_valid, invert_pixels, all_points_on, display_on, power_save;
    logic bias_1_7, scan_reverse, booster_en, regulator_en, follower_en, rmw_active, test_mode;
    logic [7:0] resp_byte, column_addr, rd_val, flags, pwr;
    logic data_write_pulse;
    logic [2:0] resistor_ratio;
    logic [5:0] volume_drive_level;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    assign flags = {4'h0, invert_pixels, all_points_on, display_on, power_save};
    assign pwr = {5'h00, booster_en, regulator_en, follower_en};

    lcdc_if bus ();
    lcdc_device #(.RESET_CYC(RST_CYC)) i_lcdc_device (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .invert_pixels(invert_pixels), .all_points_on(all_points_on), .display_on(display_on),
        .power_save(power_save), .bias_1_7(bias_1_7), .scan_reverse(scan_reverse),
        .booster_en(booster_en), .regulator_en(regulator_en), .follower_en(follower_en),
        .resistor_ratio(resistor_ratio), .volume_drive_level(volume_drive_level),
        .column_addr(column_addr), .rmw_active(rmw_active), .test_mode(test_mode),
        .data_write_pulse(data_write_pulse));
    lcdc_host #(.RESET_CYC(RST_CYC)) i_lcdc_host (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .req_valid(req_valid), .req_read(req_read), .req_is_data(req_is_data),
        .req_byte(req_byte), .req_ready(req_ready), .resp_byte(resp_byte),
        .resp_valid(resp_valid));
    lcdc_sva i_lcdc_sva (.ref_clk(ref_clk), .rst(rst), .reset_n(bus.reset_n),
        .command_data_select(bus.command_data_select), .wr_stb(bus.wr_stb),
        .rd_stb(bus.rd_stb), .wdata(bus.wdata), .rvalid(bus.rvalid),
        .invert_pixels(invert_pixels), .all_points_on(all_points_on), .display_on(display_on),
        .power_save(power_save), .bias_1_7(bias_1_7), .scan_reverse(scan_reverse),
        .booster_en(booster_en), .regulator_en(regulator_en), .follower_en(follower_en),
        .resistor_ratio(resistor_ratio), .volume_drive_level(volume_drive_level),
        .column_addr(column_addr), .rmw_active(rmw_active), .test_mode(test_mode),
        .data_write_pulse(data_write_pulse));

    always #25 ref_clk = ~ref_clk;

    // ==========================================
    // Reporting
    task automatic conclude();
        $display("mismatches %0d of %0d comparisons", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // ==========================================
    // Host user port access; the host itself polls busy before each byte
    task automatic xfer(input logic rd, input logic dat, input logic [7:0] b);
        int n;
        logic got;
        got = 1'b0;
        @(negedge ref_clk);
        while (req_ready !== 1'b1) begin
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_read <= rd;
        req_is_data <= dat;
        req_byte <= b;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        for (n = 0; n < 500; n++) begin
            @(negedge ref_clk);
            if (resp_valid === 1'b1) begin
                got = 1'b1;
                rd_val = resp_byte;
            end
            if (req_ready === 1'b1 && (got || !rd)) begin
                break;
            end
        end
    endtask : xfer

    task automatic cmd(input logic [7:0] b);
        xfer(1'b0, 1'b0, b);
    endtask : cmd

    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        // host end holds device reset after power up
        rst <= 1'b0;
        cmd(8'haf);
        xfer(1'b1, 1'b0, 8'h00);
        chk(rd_val, 8'h00);
        cmd(8'ha7);
        chk(flags, 8'h0a);
        cmd(8'ha5);
        chk(flags, 8'h06);
        cmd(8'hae);
        chk(flags, 8'h05);
        xfer(1'b1, 1'b0, 8'h00);
        chk(rd_val, 8'h20);
        cmd(8'ha4);
        chk(flags, 8'h08);
        cmd(8'ha5);
        chk(flags, 8'h05);
        cmd(8'ha4);
        cmd(8'ha6);
        chk(flags, 8'h00);
        for (int i = 0; i < 2; i++) begin
            cmd(8'ha2 | 8'(i));
            chk({7'h00, bias_1_7}, 8'(i));
        end
        cmd(8'hc8);
        chk({7'h00, scan_reverse}, 8'h01);
        cmd(8'hc7);
        chk({7'h00, scan_reverse}, 8'h00);
        cmd(8'h2f);
        chk(pwr, 8'h00);
        cmd(8'haf);
        chk(pwr, 8'h07);
        cmd(8'h2d);
        chk(pwr, 8'h05);
        for (int i = 0; i < 8; i++) begin
            cmd(8'h20 | 8'(i));
            chk({5'h00, resistor_ratio}, 8'(i));
        end
        cmd(8'h81);
        cmd(8'hff);
        chk({2'b00, volume_drive_level}, 8'h3f);
        // Command byte inside the pair must land in volume only
        cmd(8'h81);
        cmd(8'ha7);
        chk({2'b00, volume_drive_level}, 8'h27);
        chk(flags, 8'h02);
        cmd(8'h81);
        cmd({2'b00, `LCDC_VOL_DEFAULT});
        chk({2'b00, volume_drive_level}, 8'h20);
        cmd(8'h18);
        cmd(8'h02);
        chk(column_addr, 8'h82);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b0, 1'b1, 8'ha7);
            chk(column_addr, 8'h83);
        end
        chk(flags, 8'h02);
        cmd(8'h11);
        cmd(8'h00);
        cmd(8'he0);
        xfer(1'b1, 1'b1, 8'h00);
        chk(rd_val, 8'h10);
        chk(column_addr, 8'h10);
        xfer(1'b0, 1'b1, 8'h3c);
        xfer(1'b0, 1'b1, 8'h3c);
        chk(column_addr, 8'h12);
        cmd(8'hee);
        chk(column_addr, 8'h10);
        chk({7'h00, rmw_active}, 8'h00);
        cmd(8'hc8);
        cmd(8'h25);
        cmd(8'h81);
        cmd(8'h05);
        cmd(8'he0);
        cmd(8'hfc);
        chk({7'h00, test_mode}, 8'h01);
        cmd(8'he2);
        chk(column_addr, 8'h00);
        chk({5'h00, scan_reverse, rmw_active, test_mode}, 8'h00);
        chk({5'h00, resistor_ratio}, {5'h00, `LCDC_RATIO_RST});
        chk({2'b00, volume_drive_level}, {2'b00, `LCDC_VOL_RST});
        cmd(8'hfc);
        cmd(8'hc8);
        chk({6'h00, scan_reverse, test_mode}, 8'h01);
        cmd(8'he3);
        chk({6'h00, scan_reverse, test_mode}, 8'h00);
        conclude();
    end
endmodule : lcdc_bench
